// file: hw/rst_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// three-stage synchroniser; output moves once stages 2 and 3 agree
module rst_pin_sync #(
    parameter int              W       = 4,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    generate
        for (genvar i = 0; i < W; i++) begin : g_lane
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    out_ff[i] <= RST_VAL[i];
                end else if (s2_ff[i] == s3_ff[i]) begin
                    out_ff[i] <= s3_ff[i];
                end
            end
        end
    endgenerate

    assign dout = out_ff;

endmodule // rst_pin_sync
`default_nettype wire

// file: hw/rst_pkg.sv
`default_nettype none
// ==========================================================
// reset source tracker shared definitions
package rst_pkg;

    // ======================================================
    // special function register location
    localparam logic [7:0] CAUSE_REG_ADDR = 8'hEF;
    localparam logic [7:0] CAUSE_REG_PAGE = 8'h00;

    // ======================================================
    // field positions in reset_cause_and_enable
    localparam int BIT_UNUSED    = 7;
    localparam int BIT_FLASH     = 6;
    localparam int BIT_CMP       = 5;
    localparam int BIT_SW        = 4;
    localparam int BIT_WDT       = 3;
    localparam int BIT_CLK_LOSS  = 2;
    localparam int BIT_POR       = 1;
    localparam int BIT_PIN       = 0;

    // ======================================================
    // synchroniser lanes and their idle levels
    localparam int SYNC_W        = 4;
    localparam int SYNC_EXT_PIN  = 0;
    localparam int SYNC_CMP      = 1;
    localparam int SYNC_VDD_OK   = 2;
    localparam int SYNC_CLK_LOSS = 3;
    localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 4'h7;

    // ======================================================
    // reset values
    localparam logic [6:0] CAUSE_POR_VAL = 7'h02;
    localparam logic       ENABLE_RST_VAL = 1'b0;

    // ======================================================
    // timing: system reset pulse width
    localparam int CLK_PERIOD_NS   = 10;
    localparam int RST_HOLD_NS     = 1000;
    localparam int RST_HOLD_CYCLES = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ======================================================
    // types
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rst_sfr_req_t;

    // order matches bits 6..0 of the register
    typedef struct packed {
        logic flash;
        logic cmp;
        logic sw;
        logic wdt;
        logic clk_loss;
        logic por;
        logic pin;
    } rst_cause_t;

    typedef enum logic {
        ST_RUN,
        ST_HOLD
    } rst_state_t;

endpackage
`default_nettype wire

// file: hw/rst_source_tracker.sv
// Function
// - register decoded at address 0xEF, page 0x00
// - bit 6 reads 1 after flash fault reset
// - bit 5 write 1 arms comparator reset
// - bit 5 reads 1 after comparator reset
// - writing 1 to bit 4 forces reset
// - bit 4 reads 1 only after software reset
// - bit 3 reads 1 after watchdog reset
// - bit 2 write 1 arms clock-loss detector
// - armed detector resets on stopped clock
// - bit 2 reads 1 after clock-loss reset
// - bit 1 write 1 arms supply monitor
// - bit 1 set by power-on/monitor reset
// - bit 0 reads 1 after pin reset
// - bit 7 reads zero, writes ignored
// - writing 0 disarms clock-loss detector
// - armed comparator low forces one reset, which disarms it
// - internal resets never drive reset pin
`timescale 1ns/1ps
`default_nettype none
module rst_source_tracker
    import rst_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = RST_HOLD_CYCLES
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire rst_sfr_req_t sfr_req,
    output logic [7:0]        sfr_rdata,
    output logic              sfr_rvalid,
    input  wire logic         ext_rst_pin_n,
    input  wire logic         cmp_out,
    input  wire logic         vdd_ok,
    input  wire logic         clk_loss_timeout,
    input  wire logic         wdt_overflow,
    input  wire logic         flash_fault,
    output logic              sys_rst_req
);

    localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);

    // ======================================================
    // storage
    rst_state_t        state_ff;
    logic [HOLD_W-1:0] hold_cnt_ff;
    logic              sys_rst_ff;
    rst_cause_t        cause_ff;
    logic              cmp_en_ff;
    logic              clk_loss_en_ff;
    logic              vdd_en_ff;
    logic [7:0]        rdata_ff;
    logic              rvalid_ff;

    logic [SYNC_W-1:0] sync_q;
    logic              sfr_hit;
    logic              wr_hit;
    rst_cause_t        req;
    rst_cause_t        cause_sel;
    logic              any_req;
    logic              capture;
    logic              release_ok;

    // ======================================================
    // asynchronous inputs; the pin is only ever sampled, never driven
    rst_pin_sync #(
        .W       (SYNC_W),
        .RST_VAL (SYNC_RST_VAL)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   ({clk_loss_timeout, vdd_ok, cmp_out, ext_rst_pin_n}),
        .dout  (sync_q)
    );

    // ======================================================
    // register decode
    assign sfr_hit = (sfr_req.addr == CAUSE_REG_ADDR) && (sfr_req.page == CAUSE_REG_PAGE);
    // the core sits in reset during hold, so writes then are dropped
    assign wr_hit  = sfr_req.wr && sfr_hit && (state_ff == ST_RUN);

    // ======================================================
    // reset requests
    always_comb begin
        req          = '0;
        req.pin      = !sync_q[SYNC_EXT_PIN];
        req.por      = vdd_en_ff && !sync_q[SYNC_VDD_OK];
        req.clk_loss = clk_loss_en_ff && sync_q[SYNC_CLK_LOSS];
        req.cmp      = cmp_en_ff && !sync_q[SYNC_CMP];
        req.wdt      = wdt_overflow;
        req.flash    = flash_fault;
        req.sw       = wr_hit && sfr_req.wdata[BIT_SW];
    end

    // one cause recorded; the pin outranks all, software is last
    always_comb begin
        cause_sel = '0;
        if (req.pin) begin
            cause_sel.pin = 1'b1;
        end else if (req.por) begin
            cause_sel.por = 1'b1;
        end else if (req.clk_loss) begin
            cause_sel.clk_loss = 1'b1;
        end else if (req.cmp) begin
            cause_sel.cmp = 1'b1;
        end else if (req.wdt) begin
            cause_sel.wdt = 1'b1;
        end else if (req.flash) begin
            cause_sel.flash = 1'b1;
        end else if (req.sw) begin
            cause_sel.sw = 1'b1;
        end
    end

    assign any_req    = |req;
    assign capture    = (state_ff == ST_RUN) && any_req;
    // a held pin keeps the chip in reset past the minimum width
    assign release_ok = (hold_cnt_ff == '0) && sync_q[SYNC_EXT_PIN];

    // ======================================================
    // reset sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_RUN;
        end else begin
            case (state_ff)
                ST_RUN: begin
                    if (any_req) begin
                        state_ff <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (release_ok) begin
                        state_ff <= ST_RUN;
                    end
                end
                default: begin
                    state_ff <= ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt_ff <= '0;
        end else if (capture) begin
            hold_cnt_ff <= HOLD_W'(HOLD_CYCLES - 1);
        end else if (hold_cnt_ff != '0) begin
            hold_cnt_ff <= hold_cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_rst_ff <= 1'b0;
        end else if (capture) begin
            sys_rst_ff <= 1'b1;
        end else if ((state_ff == ST_HOLD) && release_ok) begin
            sys_rst_ff <= 1'b0;
        end
    end

    // ======================================================
    // cause flags: cleared only by power-on, rewritten on each reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cause_ff <= CAUSE_POR_VAL;
        end else if (capture) begin
            cause_ff <= cause_sel;
        end
    end

    // ======================================================
    // source enables; any captured reset, pin included, disarms the comparator and clock-loss sources
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_en_ff      <= ENABLE_RST_VAL;
            clk_loss_en_ff <= ENABLE_RST_VAL;
        end else if (capture) begin
            cmp_en_ff      <= ENABLE_RST_VAL;
            clk_loss_en_ff <= ENABLE_RST_VAL;
        end else if (wr_hit) begin
            cmp_en_ff      <= sfr_req.wdata[BIT_CMP];
            clk_loss_en_ff <= sfr_req.wdata[BIT_CLK_LOSS];
        end
    end

    // monitor stays armed across non-power-on resets
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vdd_en_ff <= ENABLE_RST_VAL;
        end else if (wr_hit && !capture) begin
            vdd_en_ff <= sfr_req.wdata[BIT_POR];
        end
    end

    // ======================================================
    // read path: bit 5 and bit 2 return flags, not enables
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff  <= '0;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= sfr_req.rd;
            if (sfr_req.rd && sfr_hit) begin
                rdata_ff <= {1'b0, cause_ff};
            end else begin
                rdata_ff <= '0;
            end
        end
    end

    assign sfr_rdata   = rdata_ff;
    assign sfr_rvalid  = rvalid_ff;
    assign sys_rst_req = sys_rst_ff;

    // ======================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_decode_read: assert property (
        sfr_req.rd && sfr_hit |=> sfr_rdata == {1'b0, $past(cause_ff)}
    ) else $error("register read returned wrong value");

    chk_bit7_zero: assert property (
        sfr_rdata[BIT_UNUSED] == 1'b0
    ) else $error("unused bit read as one");

    chk_sw_force: assert property (
        wr_hit && sfr_req.wdata[BIT_SW] |=> sys_rst_ff
    ) else $error("software write did not force reset");

    chk_sw_flag: assert property (
        capture && (req == cause_sel) && req.sw |=> cause_ff == 7'h10
    ) else $error("software cause flag wrong");

    chk_cmp_reset: assert property (
        (state_ff == ST_RUN) && cmp_en_ff && !sync_q[SYNC_CMP] |=> sys_rst_ff
    ) else $error("armed comparator low did not reset");

    chk_loss_reset: assert property (
        (state_ff == ST_RUN) && clk_loss_en_ff && sync_q[SYNC_CLK_LOSS]
            |=> sys_rst_ff ##0 (cause_ff.clk_loss || cause_ff.pin || cause_ff.por)
    ) else $error("clock loss did not reset");

    chk_no_spurious: assert property (
        (state_ff == ST_RUN) && !any_req && !sys_rst_ff |=> !sys_rst_ff
    ) else $error("reset without an armed source");

    chk_pin_flag: assert property (
        (state_ff == ST_RUN) && !sync_q[SYNC_EXT_PIN] |=> cause_ff == 7'h01
    ) else $error("pin reset flag not recorded");

    chk_por_flag: assert property (
        (state_ff == ST_RUN) && req.por && !req.pin |=> cause_ff == CAUSE_POR_VAL
    ) else $error("monitor reset flag not recorded");

    chk_flags_stable: assert property (
        !capture |=> $stable(cause_ff)
    ) else $error("cause flags changed without reset");

    chk_hold_width: assert property (
        $rose(sys_rst_ff) |-> sys_rst_ff[*8]
    ) else $error("system reset pulse too short");

endmodule // rst_source_tracker
`default_nettype wire

// file: verif/rst_source_tracker_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rst_source_tracker_tb_top
    import rst_pkg::*;
;
    // ==========================================================
    // stimulus and observation
    localparam int HOLD = 10;
    logic         clk              = 1'b0;
    logic         rst_n            = 1'b0;
    rst_sfr_req_t sfr_req          = '0;
    logic         ext_rst_pin_n    = 1'b1;
    logic         cmp_out          = 1'b1;
    logic         vdd_ok           = 1'b1;
    logic         clk_loss_timeout = 1'b0;
    logic         wdt_overflow     = 1'b0;
    logic         flash_fault      = 1'b0;
    logic [7:0]   sfr_rdata;
    logic         sfr_rvalid;
    logic         sys_rst_req;
    logic [7:0]   rd_val;
    int           fails            = 0;
    int           n_tests          = 0;

    always #5 clk = ~clk;

    rst_source_tracker #(.HOLD_CYCLES(HOLD)) u_rst_source_tracker (
        .clk              (clk),
        .rst_n            (rst_n),
        .sfr_req          (sfr_req),
        .sfr_rdata        (sfr_rdata),
        .sfr_rvalid       (sfr_rvalid),
        .ext_rst_pin_n    (ext_rst_pin_n),
        .cmp_out          (cmp_out),
        .vdd_ok           (vdd_ok),
        .clk_loss_timeout (clk_loss_timeout),
        .wdt_overflow     (wdt_overflow),
        .flash_fault      (flash_fault),
        .sys_rst_req      (sys_rst_req)
    );

    // ==========================================================
    // compare and report
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %b exp %b", $time, msg, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================================
    // register access: one-cycle strobe, answer sampled a cycle later
    task automatic sfr_access(input logic wr, input logic [7:0] page, input logic [7:0] addr,
                              input logic [7:0] wdata);
        @(negedge clk);
        sfr_req.wr    = wr;
        sfr_req.rd    = !wr;
        sfr_req.page  = page;
        sfr_req.addr  = addr;
        sfr_req.wdata = wdata;
        @(negedge clk);
        rd_val = sfr_rdata;
        // rvalid stands only for the cycle after a read
        chk_bit(sfr_rvalid, !wr, "rvalid");
        sfr_req = '0;
    endtask

    task automatic rd_chk(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] exp);
        sfr_access(1'b0, page, addr, 8'h00);
        chk_byte(rd_val, exp, "read data");
    endtask

    // ==========================================================
    // reset request timing
    task automatic wait_rise();
        int n;
        n = 0;
        while (sys_rst_req !== 1'b1 && n < 12) begin
            @(negedge clk);
            n++;
        end
        if (n >= 12) begin
            fails++;
            $display("[FAIL] %0t reset request never rose", $time);
            print_verdict();
        end
    endtask

    // hold is a minimum; the pin may stretch it a few cycles
    task automatic wait_fall();
        int n;
        n = 0;
        while (sys_rst_req === 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n >= 300) begin
            fails++;
            $display("[FAIL] %0t reset request stuck", $time);
            print_verdict();
        end else begin
            chk_bit(n >= HOLD, 1'b1, "hold width");
        end
    endtask

    task automatic quiet(input string msg);
        logic seen;
        seen = 1'b0;
        repeat (20) begin
            @(negedge clk);
            seen = seen | sys_rst_req;
        end
        chk_bit(seen, 1'b0, msg);
    endtask

    // 0 pin, 1 monitor, 2 clock loss, 3 comparator, 4 watchdog, 5 flash
    task automatic run_src(input int src, input logic [7:0] exp);
        @(negedge clk);
        case (src)
            0: ext_rst_pin_n = 1'b0;
            1: vdd_ok = 1'b0;
            2: clk_loss_timeout = 1'b1;
            3: cmp_out = 1'b0;
            4: wdt_overflow = 1'b1;
            default: flash_fault = 1'b1;
        endcase
        wait_rise();
        ext_rst_pin_n    = 1'b1;
        vdd_ok           = 1'b1;
        clk_loss_timeout = 1'b0;
        cmp_out          = 1'b1;
        wdt_overflow     = 1'b0;
        flash_fault      = 1'b0;
        wait_fall();
        rd_chk(8'h00, 8'hEF, exp);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        rd_chk(8'h00, 8'hEF, 8'h02);
        rd_chk(8'h01, 8'hEF, 8'h00);
        rd_chk(8'h00, 8'hEE, 8'h00);
        sfr_access(1'b1, 8'h00, 8'hEF, 8'hC9);
        rd_chk(8'h00, 8'hEF, 8'h02);
        sfr_access(1'b1, 8'h00, 8'hEE, 8'h10);
        quiet("stray write reset");
        sfr_access(1'b1, 8'h00, 8'hEF, 8'h10);
        chk_bit(sys_rst_req, 1'b1, "software reset");
        wait_fall();
        rd_chk(8'h00, 8'hEF, 8'h10);
        run_src(4, 8'h08);
        run_src(5, 8'h40);
        run_src(0, 8'h01);
        // comparator low while disarmed must not reset
        cmp_out = 1'b0;
        quiet("disarmed comparator");
        cmp_out = 1'b1;
        // synchroniser must show the comparator high before arming
        repeat (4) @(negedge clk);
        sfr_access(1'b1, 8'h00, 8'hEF, 8'h20);
        run_src(3, 8'h20);
        sfr_access(1'b1, 8'h00, 8'hEF, 8'h04);
        run_src(2, 8'h04);
        sfr_access(1'b1, 8'h00, 8'hEF, 8'h04);
        sfr_access(1'b1, 8'h00, 8'hEF, 8'h00);
        clk_loss_timeout = 1'b1;
        quiet("disarmed clock loss");
        clk_loss_timeout = 1'b0;
        // monitor armed only while the supply reads good
        sfr_access(1'b1, 8'h00, 8'hEF, 8'h02);
        run_src(1, 8'h02);
        print_verdict();
    end

endmodule // rst_source_tracker_tb_top
`default_nettype wire
